// [logic/sdec_start_io.sv]
// start-i/o validity check and diagnose translator mode decode
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module sdec_start_io (
    input  wire logic                             sys_clk_in,
    input  wire logic                             reset_in,
    input  wire logic                             start_in,
    input  wire logic                             diag_in,
    input  wire logic [sdec_pkg::CAW_W-1:0]       channel_address_word_in,
    input  wire logic [sdec_pkg::GR_W-1:0]        general_register_in,
    input  wire logic                             ccw_valid_in,
    input  wire logic [sdec_pkg::CCW_W-1:0]       channel_command_word_in,
    output logic                                  busy_out,
    output logic                                  done_out,
    output logic                                  program_check_out,
    output logic                                  status_store_out,
    output logic                                  transfer_go_out,
    output logic [3:0]                            tape_disk_mode_out,
    output logic                                  mode_disk_out,
    output logic                                  mode_load_out,
    output logic                                  mode_odd_parity_out,
    output logic                                  mode_illegal_out,
    output sdec_pkg::sdec_xlat_t                  xlat_out,
    output logic [sdec_pkg::UNIT_ADDR_W-1:0]      unit_address_out
);
    typedef enum logic [1:0] {SDEC_IDLE, SDEC_CCW, SDEC_DONE} sdec_state_t;

    sdec_state_t                        state_q, state_d;
    logic                               diag_q, diag_d;
    logic                               pchk_q, pchk_d;
    logic                               store_q, store_d;
    logic                               go_q, go_d;
    logic                               done_q, done_d;
    logic [3:0]                         mode_q, mode_d;
    logic                               illegal_q, illegal_d;
    logic                               disk_q, disk_d;
    logic                               load_q, load_d;
    logic                               odd_q, odd_d;
    sdec_pkg::sdec_xlat_t               xlat_q, xlat_d;
    logic [sdec_pkg::UNIT_ADDR_W-1:0]   unit_q, unit_d;
    logic                               caw_bad;
    logic                               ccw_bad;
    sdec_pkg::sdec_xlat_t               ccw_xlat;
    logic [3:0]                         caw_mode;

    assign caw_mode = channel_address_word_in[sdec_pkg::CAW_MODE_HI_POS:
                                              sdec_pkg::CAW_MODE_LO_POS];

    // normal form: reserved nibble; diagnose form: bit 5 must be set
    always_comb begin
        if (diag_in) begin
            caw_bad = !channel_address_word_in[sdec_pkg::CAW_DIAG_POS];
        end else begin
            caw_bad = (caw_mode != 4'h0);
        end
    end

    sdec_ccw_check u_ccw_check (
        .ccw_in           (channel_command_word_in),
        .diag_in          (diag_q),
        .reserved_bad_out (ccw_bad),
        .xlat_out         (ccw_xlat)
    );

    always_comb begin
        state_d   = state_q;
        diag_d    = diag_q;
        pchk_d    = pchk_q;
        store_d   = 1'b0;
        go_d      = 1'b0;
        done_d    = 1'b0;
        mode_d    = mode_q;
        illegal_d = illegal_q;
        disk_d    = disk_q;
        load_d    = load_q;
        odd_d     = odd_q;
        xlat_d    = xlat_q;
        unit_d    = unit_q;
        case (state_q)
            SDEC_IDLE: begin
                if (start_in) begin
                    diag_d    = diag_in;
                    pchk_d    = caw_bad;
                    // nibble is only translator control in diagnose form
                    mode_d    = diag_in ? caw_mode : 4'h0;
                    illegal_d = diag_in && ((caw_mode == sdec_pkg::MODE_ILLEGAL_A) ||
                                            (caw_mode == sdec_pkg::MODE_ILLEGAL_B));
                    // codes decode: bit0 disk, bit1 load, bit3 odd parity (tape only)
                    disk_d    = diag_in && caw_mode[0] && !caw_mode[3];
                    load_d    = diag_in && caw_mode[1];
                    odd_d     = diag_in && caw_mode[3] && !illegal_d;
                    unit_d    = diag_in ? general_register_in[sdec_pkg::UNIT_ADDR_W-1:0]
                                        : unit_q;
                    xlat_d    = sdec_pkg::SDEC_XLAT_NONE;
                    if (caw_bad) begin
                        store_d = 1'b1;
                        done_d  = 1'b1;
                        state_d = SDEC_DONE;
                    end else begin
                        state_d = SDEC_CCW;
                    end
                end
            end
            SDEC_CCW: begin
                if (ccw_valid_in) begin
                    xlat_d = diag_q ? ccw_xlat : sdec_pkg::SDEC_XLAT_NONE;
                    if (ccw_bad) begin
                        pchk_d  = 1'b1;
                        store_d = 1'b1;
                    end else begin
                        go_d = 1'b1;
                    end
                    done_d  = 1'b1;
                    state_d = SDEC_DONE;
                end
            end
            SDEC_DONE: begin
                state_d = SDEC_IDLE;
            end
            default: begin
                state_d = SDEC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_q   <= SDEC_IDLE;
            diag_q    <= 1'b0;
            pchk_q    <= 1'b0;
            store_q   <= 1'b0;
            go_q      <= 1'b0;
            done_q    <= 1'b0;
            mode_q    <= 4'h0;
            illegal_q <= 1'b0;
            disk_q    <= 1'b0;
            load_q    <= 1'b0;
            odd_q     <= 1'b0;
            xlat_q    <= sdec_pkg::SDEC_XLAT_NONE;
            unit_q    <= '0;
        end else begin
            state_q   <= state_d;
            diag_q    <= diag_d;
            pchk_q    <= pchk_d;
            store_q   <= store_d;
            go_q      <= go_d;
            done_q    <= done_d;
            mode_q    <= mode_d;
            illegal_q <= illegal_d;
            disk_q    <= disk_d;
            load_q    <= load_d;
            odd_q     <= odd_d;
            xlat_q    <= xlat_d;
            unit_q    <= unit_d;
        end
    end

    assign busy_out            = (state_q != SDEC_IDLE);
    assign done_out            = done_q;
    assign program_check_out   = pchk_q;
    assign status_store_out    = store_q;
    assign transfer_go_out     = go_q;
    assign tape_disk_mode_out  = mode_q;
    assign mode_disk_out       = disk_q;
    assign mode_load_out       = load_q;
    assign mode_odd_parity_out = odd_q;
    assign mode_illegal_out    = illegal_q;
    assign xlat_out            = xlat_q;
    assign unit_address_out    = unit_q;

    property p_caw_check;
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_IDLE && start_in && !diag_in && caw_mode != 4'h0)
            |=> (status_store_out && program_check_out && !transfer_go_out);
    endproperty
    caw_reserved_a: assert property (p_caw_check)
        else $error("reserved address nibble not flagged");

    ccw_reserved_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_CCW && ccw_valid_in && !diag_q && ccw_bad) |=> program_check_out)
        else $error("reserved command bits not flagged");

    check_store_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        status_store_out |-> (program_check_out && done_out))
        else $error("status store without program check");

    diag_suppress_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_IDLE && start_in && diag_in &&
         channel_address_word_in[sdec_pkg::CAW_DIAG_POS]) |=> !program_check_out)
        else $error("diagnose form raised check on mode bits");

    diag_bit5_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_IDLE && start_in && diag_in &&
         !channel_address_word_in[sdec_pkg::CAW_DIAG_POS])
            |=> (program_check_out && status_store_out) ##1 (state_q == SDEC_IDLE))
        else $error("diagnose without bit 5 not checked");

    mode_capture_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_IDLE && start_in && diag_in)
            |=> (tape_disk_mode_out == $past(caw_mode)))
        else $error("mode nibble not captured");

    mode_illegal_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        mode_illegal_out |-> (tape_disk_mode_out[3] && tape_disk_mode_out[0]))
        else $error("illegal flag on legal code");

    go_after_check_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        transfer_go_out |-> (!program_check_out && done_out))
        else $error("transfer started despite check");

    unit_addr_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_IDLE && start_in && diag_in)
            |=> (unit_address_out == $past(general_register_in[10:0])))
        else $error("unit address not taken");

    busy_start_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_IDLE && start_in) |=> busy_out)
        else $error("start request not taken");

    caw_clean_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_IDLE && start_in && !diag_in && caw_mode == 4'h0)
            |=> (!program_check_out && !status_store_out && state_q == SDEC_CCW))
        else $error("clean address word rejected");

    tic_exempt_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_CCW && ccw_valid_in && !diag_q &&
         channel_command_word_in[sdec_pkg::CCW_CMD_LO_POS+3:sdec_pkg::CCW_CMD_LO_POS] ==
         sdec_pkg::CMD_TIC_LOW) |=> (transfer_go_out && !program_check_out))
        else $error("transfer-in-channel word flagged");

    ccw_clean_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_CCW && ccw_valid_in && !diag_q &&
         channel_command_word_in[sdec_pkg::CCW_XL_HI_POS:sdec_pkg::CCW_XL_LO_POS] == 2'h0)
            |=> (transfer_go_out && !status_store_out))
        else $error("clean command word rejected");

    store_pulse_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        status_store_out |=> !status_store_out)
        else $error("status store longer than one cycle");

    check_holds_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (program_check_out && !(state_q == SDEC_IDLE && start_in)) |=> program_check_out)
        else $error("program check lost before next start");

    diag_ccw_quiet_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_CCW && ccw_valid_in && diag_q) |=> (transfer_go_out && !status_store_out))
        else $error("diagnose form checked command bits");

    diag_xlat_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_CCW && ccw_valid_in && diag_q) |=> (xlat_out == $past(ccw_xlat)))
        else $error("translator control not taken");

    normal_mode_zero_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_IDLE && start_in && !diag_in)
            |=> (tape_disk_mode_out == 4'h0 && !mode_illegal_out && !mode_odd_parity_out))
        else $error("normal form selected a translator mode");

    tape_move_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (tape_disk_mode_out == sdec_pkg::MODE_TAPE_MOVE)
            |-> (!mode_disk_out && !mode_load_out && !mode_odd_parity_out))
        else $error("tape move flags wrong");

    disk_move_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (tape_disk_mode_out == sdec_pkg::MODE_DISK_MOVE)
            |-> (mode_disk_out && !mode_load_out && !mode_odd_parity_out))
        else $error("disk move flags wrong");

    tape_load_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (tape_disk_mode_out == sdec_pkg::MODE_TAPE_LOAD)
            |-> (!mode_disk_out && mode_load_out && !mode_odd_parity_out))
        else $error("tape load flags wrong");

    disk_load_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (tape_disk_mode_out == sdec_pkg::MODE_DISK_LOAD)
            |-> (mode_disk_out && mode_load_out && !mode_odd_parity_out))
        else $error("disk load flags wrong");

    odd_move_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (tape_disk_mode_out == sdec_pkg::MODE_TAPE_MOVE_ODD)
            |-> (!mode_disk_out && !mode_load_out && mode_odd_parity_out && !mode_illegal_out))
        else $error("odd tape move flags wrong");

    odd_load_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (tape_disk_mode_out == sdec_pkg::MODE_TAPE_LOAD_ODD)
            |-> (!mode_disk_out && mode_load_out && mode_odd_parity_out && !mode_illegal_out))
        else $error("odd tape load flags wrong");

    illegal_code_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (tape_disk_mode_out == sdec_pkg::MODE_ILLEGAL_A ||
         tape_disk_mode_out == sdec_pkg::MODE_ILLEGAL_B) |-> (mode_illegal_out && !mode_odd_parity_out))
        else $error("illegal code not flagged");

    xlat_load_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_CCW && ccw_valid_in && diag_q &&
         channel_command_word_in[sdec_pkg::CCW_XL_HI_POS:sdec_pkg::CCW_XL_LO_POS] == 2'h2)
            |=> (xlat_out == sdec_pkg::SDEC_XLAT_LOAD_READ))
        else $error("load-mode read not selected");

    xlat_read_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_CCW && ccw_valid_in && diag_q && channel_command_word_in[25:24] == 2'h3 &&
         channel_command_word_in[57:56] != 2'h1)
            |=> (xlat_out == sdec_pkg::SDEC_XLAT_MOVE_WORDMARK))
        else $error("read move mode not selected");

    xlat_write_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_CCW && ccw_valid_in && diag_q && channel_command_word_in[25:24] == 2'h3 &&
         channel_command_word_in[57:56] == 2'h1)
            |=> (xlat_out == sdec_pkg::SDEC_XLAT_WRITE))
        else $error("write translation not selected");

    unit_keep_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_IDLE && start_in && !diag_in) |=> $stable(unit_address_out))
        else $error("normal start changed unit address");

    go_pulse_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        transfer_go_out |=> !transfer_go_out)
        else $error("transfer go longer than one cycle");

    caw_no_go_a: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (state_q == SDEC_IDLE && start_in && caw_bad)
            |=> (done_out && !transfer_go_out) ##1 (!transfer_go_out && !busy_out))
        else $error("transfer after address word check");
endmodule : sdec_start_io

// [shared/sdec_pkg.sv]
// constants for the start-i/o validity and translator mode decoder
package sdec_pkg;
    localparam int CAW_W           = 32;
    localparam int CCW_W           = 64;
    localparam int GR_W            = 32;
    localparam int UNIT_ADDR_W     = 11;
    // big-endian bit numbering: bit n sits at index (width-1-n)
    localparam int CAW_MODE_HI_POS = CAW_W - 1 - 4;
    localparam int CAW_MODE_LO_POS = CAW_W - 1 - 7;
    localparam int CAW_DIAG_POS    = CAW_W - 1 - 5;
    localparam int CCW_XL_HI_POS   = CCW_W - 1 - 38;
    localparam int CCW_XL_LO_POS   = CCW_W - 1 - 39;
    localparam int CCW_CMD_HI_POS  = CCW_W - 1;
    localparam int CCW_CMD_LO_POS  = CCW_W - 8;
    // transfer-in-channel command: low nibble x8
    localparam logic [3:0] CMD_TIC_LOW = 4'h8;

    localparam logic [3:0] MODE_TAPE_MOVE     = 4'h4;
    localparam logic [3:0] MODE_DISK_MOVE     = 4'h5;
    localparam logic [3:0] MODE_TAPE_LOAD     = 4'h6;
    localparam logic [3:0] MODE_DISK_LOAD     = 4'h7;
    localparam logic [3:0] MODE_TAPE_MOVE_ODD = 4'hc;
    localparam logic [3:0] MODE_ILLEGAL_A     = 4'hd;
    localparam logic [3:0] MODE_TAPE_LOAD_ODD = 4'he;
    localparam logic [3:0] MODE_ILLEGAL_B     = 4'hf;

    localparam logic [1:0] XL_NONE    = 2'h0;
    localparam logic [1:0] XL_UNDEF   = 2'h1;
    localparam logic [1:0] XL_LOAD_RD = 2'h2;
    localparam logic [1:0] XL_MOVE_WR = 2'h3;

    typedef enum logic [2:0] {
        SDEC_XLAT_NONE,
        SDEC_XLAT_UNDEF,
        SDEC_XLAT_LOAD_READ,
        SDEC_XLAT_MOVE_WORDMARK,
        SDEC_XLAT_WRITE
    } sdec_xlat_t;
endpackage : sdec_pkg

// [logic/sdec_ccw_check.sv]
// per-command-word reserved bit check and translation decode
`timescale 1ns/1ps
module sdec_ccw_check (
    input  wire logic [sdec_pkg::CCW_W-1:0] ccw_in,
    input  wire logic                       diag_in,
    output logic                            reserved_bad_out,
    output sdec_pkg::sdec_xlat_t            xlat_out
);
    logic [1:0] xl_bits;
    logic [7:0] cmd;
    logic       is_tic;
    logic       is_write;

    assign xl_bits = ccw_in[sdec_pkg::CCW_XL_HI_POS:sdec_pkg::CCW_XL_LO_POS];
    assign cmd     = ccw_in[sdec_pkg::CCW_CMD_HI_POS:sdec_pkg::CCW_CMD_LO_POS];
    assign is_tic  = (cmd[3:0] == sdec_pkg::CMD_TIC_LOW);
    // write commands have low two bits 01
    assign is_write = (cmd[1:0] == 2'h1);

    // tic words are exempt; diagnose form never flags
    assign reserved_bad_out = !diag_in && !is_tic && (xl_bits != 2'h0);

    always_comb begin
        case (xl_bits)
            sdec_pkg::XL_NONE:    xlat_out = sdec_pkg::SDEC_XLAT_NONE;
            sdec_pkg::XL_UNDEF:   xlat_out = sdec_pkg::SDEC_XLAT_UNDEF;
            sdec_pkg::XL_LOAD_RD: xlat_out = sdec_pkg::SDEC_XLAT_LOAD_READ;
            sdec_pkg::XL_MOVE_WR: xlat_out = is_write ? sdec_pkg::SDEC_XLAT_WRITE
                                                      : sdec_pkg::SDEC_XLAT_MOVE_WORDMARK;
            default:              xlat_out = sdec_pkg::SDEC_XLAT_NONE;
        endcase
    end
endmodule : sdec_ccw_check

// [tb/sdec_prog_model.sv]
// issuing program model: start request, address word, general register, command word
`timescale 1ns/1ps
module sdec_prog_model (
    input  wire logic                  sys_clk_in,
    input  wire logic                  done_in,
    input  wire logic                  store_in,
    input  wire logic                  go_in,
    output logic                       start_out,
    output logic                       diag_out,
    output logic [sdec_pkg::CAW_W-1:0] caw_out,
    output logic [sdec_pkg::GR_W-1:0]  gr_out,
    output logic                       ccw_valid_out,
    output logic [sdec_pkg::CCW_W-1:0] ccw_out
);
    int   n_done    = 0;
    logic cap_store = 1'b0;
    logic cap_go    = 1'b0;
    initial begin
        start_out     = 1'b0;
        diag_out      = 1'b0;
        caw_out       = 32'h0;
        gr_out        = 32'h0;
        ccw_valid_out = 1'b0;
        ccw_out       = 64'h0;
    end
    // pulses stand one cycle, so grab them at the edge after done
    always @(posedge sys_clk_in) begin
        if (done_in === 1'b1) begin
            cap_store <= store_in;
            cap_go    <= go_in;
            n_done    <= n_done + 1;
        end
    end
    task automatic issue(input logic d, input logic [31:0] channel_address_word, input logic [31:0] gr,
                         input logic [63:0] ccw, output logic ok);
        int n0;
        n0 = n_done;
        @(posedge sys_clk_in);
        start_out <= 1'b1;
        diag_out  <= d;
        caw_out   <= channel_address_word;
        gr_out    <= gr;
        @(posedge sys_clk_in);
        // released words turn over so a late sample shows up as wrong
        start_out     <= 1'b0;
        diag_out      <= ~d;
        caw_out       <= ~channel_address_word;
        gr_out        <= ~gr;
        ccw_valid_out <= 1'b1;
        ccw_out       <= ccw;
        @(posedge sys_clk_in);
        ccw_valid_out <= 1'b0;
        ccw_out       <= ~ccw;
        for (int k = 0; k < 20 && n_done == n0; k++) @(posedge sys_clk_in);
        ok = (n_done != n0);
        @(posedge sys_clk_in);
        @(posedge sys_clk_in);
    endtask : issue
endmodule : sdec_prog_model

// [tb/sdec_start_io_tb_top.sv]
// self-checking bench for the start-i/o validity and mode decoder
`timescale 1ns/1ps
module sdec_start_io_tb_top;
    logic                 sys_clk_in = 1'b0;
    logic                 reset_in   = 1'b1;
    logic                 start, diag, ccw_valid, busy, done, pc, store, go;
    logic                 m_disk, m_load, m_odd, m_ill;
    logic [31:0]          channel_address_word, gr;
    logic [63:0]          ccw;
    logic [3:0]           mode;
    logic [10:0]          unit;
    sdec_pkg::sdec_xlat_t xlat;
    logic [31:0]          gr_v = 32'h0;
    int                   n_fail = 0;
    int                   check_count = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    sdec_prog_model prog (.sys_clk_in(sys_clk_in), .done_in(done), .store_in(store),
        .go_in(go), .start_out(start), .diag_out(diag), .caw_out(channel_address_word), .gr_out(gr),
        .ccw_valid_out(ccw_valid), .ccw_out(ccw));
    sdec_start_io uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .start_in(start),
        .diag_in(diag), .channel_address_word_in(channel_address_word), .general_register_in(gr),
        .ccw_valid_in(ccw_valid), .channel_command_word_in(ccw), .busy_out(busy),
        .done_out(done), .program_check_out(pc), .status_store_out(store),
        .transfer_go_out(go), .tape_disk_mode_out(mode), .mode_disk_out(m_disk),
        .mode_load_out(m_load), .mode_odd_parity_out(m_odd), .mode_illegal_out(m_ill),
        .xlat_out(xlat), .unit_address_out(unit));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input logic d, input logic [3:0] c, input logic [1:0] xl,
                       input logic [7:0] cmd);
        logic ok;
        prog.issue(d, {4'h0, c, 24'h001040}, gr_v, {cmd, 30'h0, xl, 24'h0}, ok);
        chk(16'(ok), 16'h1);
    endtask : run
    // a check must store status and hold back the transfer
    task automatic outc(input logic p);
        chk(16'({prog.cap_store, prog.cap_go, pc}), 16'({p, ~p, p}));
    endtask : outc
    task automatic print_verdict();
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic t_caw_fault();
        for (int i = 0; i < 4; i++) begin
            run(1'b0, 4'h1 << i, 2'h0, 8'h02);
            outc(1'b1);
        end
    endtask : t_caw_fault
    task automatic t_ccw_fault();
        run(1'b0, 4'h0, 2'h1, 8'h02);
        outc(1'b1);
        run(1'b0, 4'h0, 2'h2, 8'h01);
        outc(1'b1);
        run(1'b0, 4'h0, 2'h3, 8'h08);
        outc(1'b0);
    endtask : t_ccw_fault
    task automatic t_diag_modes();
        logic [3:0] c;
        logic [3:0] codes [6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'he};
        // expected {disk, load, odd, illegal} for each code above
        logic [3:0] flags [6] = '{4'h0, 4'h8, 4'h4, 4'hc, 4'h2, 4'h6};
        foreach (codes[i]) begin
            c    = codes[i];
            gr_v = 32'hfff0_0300 + 32'(i) * 32'h111;
            run(1'b1, c, 2'h0, 8'h02);
            outc(1'b0);
            chk(16'(mode), 16'(c));
            chk(16'({m_disk, m_load, m_odd, m_ill}), 16'(flags[i]));
            chk(16'(unit), 16'(gr_v[10:0]));
        end
        for (int i = 0; i < 2; i++) begin
            run(1'b1, 4'hd + 4'(2 * i), 2'h0, 8'h02);
            chk(16'(m_ill), 16'h1);
        end
    endtask : t_diag_modes
    task automatic t_diag_bit5();
        run(1'b1, 4'h8, 2'h0, 8'h02);
        outc(1'b1);
        run(1'b1, 4'h0, 2'h0, 8'h02);
        outc(1'b1);
    endtask : t_diag_bit5
    // bits 11 split on the read or write command
    task automatic t_xlat();
        for (int i = 0; i < 5; i++) begin
            run(1'b1, 4'h4, (i < 4) ? 2'(i) : 2'h3, (i == 4) ? 8'h01 : 8'h02);
            outc(1'b0);
            chk(16'(xlat), 16'(i));
        end
    endtask : t_xlat
    task automatic t_normal_ok();
        run(1'b0, 4'h0, 2'h0, 8'h02);
        outc(1'b0);
        chk(16'({mode, 3'(xlat)}), 16'h0);
        // normal form leaves the last diagnose unit address in place
        chk(16'(unit), 16'h07ff);
    endtask : t_normal_ok
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        @(posedge sys_clk_in);
        #1;
        chk(16'({busy, done, pc, store, go}), 16'h0);
        t_caw_fault();
        t_ccw_fault();
        t_diag_modes();
        t_diag_bit5();
        t_xlat();
        gr_v = 32'h0000_07ff;
        run(1'b1, 4'h5, 2'h0, 8'h02);
        gr_v = 32'h0000_0000;
        t_normal_ok();
        print_verdict();
    end
endmodule : sdec_start_io_tb_top
